/* File: inc/sctx_pkg.sv */
// constants for the stream-to-context and tlb sync register bank
// assumes a single ahb-lite slave port and one clock domain
// Operation
// - status bit 0 shows sync in progress
// - status is read-only, upper bits reserved
// - sync write completes earlier accepted invalidations
// - sync and status banked per security state
// - secure aliases reach non-secure sync and status
// - sync register write-only, data ignored
// - matching group gives initial context, type 17:16
// - unimplemented group slots read zero, ignore writes
// - extended matching maps onto last 128 groups
// - group registers read-write, reset undefined
// - transient override in bits 29:28
// - fetch kind override in bits 27:26
// - writes always marked as data downstream
// - privilege override 25:24, code 01 access-never
// - hypervisor and monitor banks marked privileged
// - write-allocate override in bits 23:22
// - read-allocate override in bits 21:20
// - security override 19:18 only in secure groups
// - type decode translate, bypass, fault, fault
// - bits 7:0 select context bank
// - attribute code 15:12 used only when select set
// - fault context type raises invalid context fault
`default_nettype none
package sctx_pkg;
    // byte offsets within the register page
    localparam logic [11:0] OFF_NS_SYNC = 12'h000;
    localparam logic [11:0] OFF_NS_STAT = 12'h004;
    localparam logic [11:0] OFF_AL_SYNC = 12'h008;
    localparam logic [11:0] OFF_AL_STAT = 12'h00C;
    localparam logic [11:0] OFF_SEC_GRP = 12'h010;
    localparam logic [11:0] OFF_S2CR = 12'h400;
    // field positions of a stream-to-context word
    localparam int F_TRANS = 28;
    localparam int F_FETCH = 26;
    localparam int F_PRIV = 24;
    localparam int F_WALLOC = 22;
    localparam int F_RALLOC = 20;
    localparam int F_SEC = 18;
    localparam int F_TYPE = 16;
    localparam int F_MATTR = 12;
    localparam int F_MTSEL = 11;
    localparam int F_SHARE = 8;
    localparam int F_CONTEXT_BANK_INDEX = 0;
    // implemented bits; 31:30 and 10 are not stored
    localparam logic [31:0] S2CR_WMASK = 32'h3FFF_FBFF;
    localparam logic [31:0] SEC_FIELD_MASK = 32'h000C_0000;
    // override codes shared by the two-bit override fields in bits 29:18
    localparam logic [1:0] OV_DEFAULT = 2'h0;
    localparam logic [1:0] OV_RSVD = 2'h1;
    localparam logic [1:0] OV_LOW = 2'h2;
    localparam logic [1:0] OV_HIGH = 2'h3;
    // number of groups the extended map places last
    localparam int EXT_TAIL = 128;
    // initial context types
    typedef enum logic [1:0] {
        CTX_TRANSLATE = 2'h0,
        CTX_BYPASS = 2'h1,
        CTX_FAULT = 2'h2,
        CTX_FAULT_RSVD = 2'h3
    } sctx_ctx_t;
    // bus slave sequencing, one-hot
    typedef enum logic [2:0] {
        BS_IDLE = 3'b001,
        BS_RD_WAIT = 3'b010,
        BS_RD_DONE = 3'b100
    } sctx_bus_t;
endpackage : sctx_pkg
`default_nettype wire

/* File: rtl/sctx_regs.sv */
// tlb sync banks and per-group stream-to-context registers
// assumes ahb-lite single word transfers and invalidation events from the tlb
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`default_nettype none
module sctx_regs #(
    parameter int N_GROUPS = 16,
    parameter int N_IMPL = 16,
    parameter int CNT_W = 8,
    parameter int EXT_TOTAL = 1024
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hnonsec,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic inv_accept,
    input wire logic inv_accept_nonsec,
    input wire logic inv_done,
    input wire logic inv_done_nonsec,
    input wire logic access_never_support_flag,
    input wire logic ext_match_enable,
    input wire logic txn_valid,
    input wire logic [9:0] txn_group,
    input wire logic txn_write,
    input wire logic txn_instr,
    input wire logic txn_priv,
    input wire logic txn_transient,
    input wire logic txn_walloc,
    input wire logic txn_ralloc,
    input wire logic txn_nonsec,
    input wire logic [1:0] txn_share,
    input wire logic [3:0] txn_mattr,
    input wire logic txn_hyp_mon_bank,
    output logic out_valid,
    output logic [1:0] out_ctx_type,
    output logic [7:0] out_cb_index,
    output logic out_fault,
    output logic out_instr,
    output logic out_priv,
    output logic out_pan,
    output logic out_transient,
    output logic out_walloc,
    output logic out_ralloc,
    output logic out_nonsec,
    output logic [1:0] out_share,
    output logic [3:0] out_mattr,
    output logic sync_active_ns,
    output logic sync_active_s
);
    localparam int GW = $clog2(N_GROUPS + 1);
    localparam int IW = $clog2(N_GROUPS);
    localparam logic [9:0] EXT_BASE = 10'(EXT_TOTAL - sctx_pkg::EXT_TAIL);

    sctx_pkg::sctx_bus_t bus_r; // slave sequencing state
    logic [11:0] dp_addr_r; // latched address of data phase
    logic dp_wr_r; // write data phase pending
    logic dp_sec_r; // latched access security, 1 = secure
    logic [31:0] hrdata_r; // registered read data
    logic [31:0] rd_nxt; // read value before capture
    logic [31:0] s2cr_r [N_GROUPS]; // group registers, no reset
    logic [GW-1:0] sec_cnt_r; // groups below this index are secure
    logic [1:0] flag_r; // sync active, index 0 non-secure, 1 secure
    logic [CNT_W-1:0] outst_r [2]; // invalidations still running
    logic [CNT_W-1:0] pend_r [2]; // of those, accepted before the sync
    logic [1:0] sync_wr; // sync write strobe per bank
    logic [1:0] acc_b; // accepted invalidation per bank
    logic [1:0] done_b; // completed invalidation per bank
    logic addr_take; // address phase accepted this cycle
    logic in_s2cr; // data phase address hits group window
    logic [IW-1:0] widx; // group index from bus address
    logic w_ok; // group slot exists and access may reach it

    // address phase is taken only when the bus is ready
    assign addr_take = ce & hsel & htrans[1] & hready;
    assign hresp = 1'b0;
    // read stalls one cycle so the read sees completed writes; ce low stalls a pending write or a read
    assign hreadyout = (bus_r == sctx_pkg::BS_IDLE) ? (ce | ~dp_wr_r) :
                       (bus_r == sctx_pkg::BS_RD_DONE) & ce;
    assign hrdata = hrdata_r;

    // group window decode and access permission
    assign in_s2cr = dp_addr_r[11:10] == sctx_pkg::OFF_S2CR[11:10];
    assign widx = dp_addr_r[IW+1:2];
    // missing slots and secure groups from non-secure are inert
    assign w_ok = in_s2cr && (dp_addr_r[9:2] < 8'(N_IMPL)) &&
                  (dp_sec_r || ({1'b0, widx} >= (IW+1)'(sec_cnt_r)));

    // bus sequencing: latch address, then write or stall for read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_r <= sctx_pkg::BS_IDLE;
            dp_addr_r <= 12'h000;
            dp_wr_r <= 1'b0;
            dp_sec_r <= 1'b0;
        end else if (ce) begin
            unique case (bus_r)
                sctx_pkg::BS_IDLE: begin
                    dp_wr_r <= addr_take & hwrite;
                    if (addr_take) begin
                        dp_addr_r <= haddr;
                        dp_sec_r <= ~hnonsec;
                    end
                    if (addr_take & ~hwrite) begin
                        bus_r <= sctx_pkg::BS_RD_WAIT;
                    end
                end
                sctx_pkg::BS_RD_WAIT: begin
                    bus_r <= sctx_pkg::BS_RD_DONE;
                end
                sctx_pkg::BS_RD_DONE: begin
                    // next address phase may overlap the read completion
                    dp_wr_r <= addr_take & hwrite;
                    if (addr_take) begin
                        dp_addr_r <= haddr;
                        dp_sec_r <= ~hnonsec;
                    end
                    bus_r <= (addr_take & ~hwrite) ? sctx_pkg::BS_RD_WAIT :
                             sctx_pkg::BS_IDLE;
                end
            endcase
        end
    end

    // sync strobes: own bank, or ns bank via secure alias
    always_comb begin
        sync_wr = 2'b00;
        if (dp_wr_r && bus_r == sctx_pkg::BS_IDLE) begin
            if (dp_addr_r == sctx_pkg::OFF_NS_SYNC) begin
                sync_wr[dp_sec_r] = 1'b1;
            end else if (dp_addr_r == sctx_pkg::OFF_AL_SYNC && dp_sec_r) begin
                sync_wr[0] = 1'b1;
            end
        end
    end

    // invalidation events sorted by security state
    assign acc_b = {inv_accept & ~inv_accept_nonsec, inv_accept & inv_accept_nonsec};
    assign done_b = {inv_done & ~inv_done_nonsec, inv_done & inv_done_nonsec};

    // per-bank tracking; completions come in acceptance order
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 2'b00;
            for (int b = 0; b < 2; b++) begin
                outst_r[b] <= '0;
                pend_r[b] <= '0;
            end
        end else if (ce) begin
            for (int b = 0; b < 2; b++) begin
                outst_r[b] <= outst_r[b] + CNT_W'(acc_b[b]) - CNT_W'(done_b[b]);
                if (sync_wr[b]) begin
                    // snapshot what was accepted before this write
                    pend_r[b] <= outst_r[b] - CNT_W'(done_b[b]);
                    flag_r[b] <= 1'b1;
                end else begin
                    if (done_b[b] && pend_r[b] != '0) begin
                        pend_r[b] <= pend_r[b] - CNT_W'(1);
                    end
                    // set beats clear: a new sync keeps the flag up
                    if (flag_r[b] && pend_r[b] == '0) begin
                        flag_r[b] <= 1'b0;
                    end
                end
            end
        end
    end
    assign sync_active_ns = flag_r[0];
    assign sync_active_s = flag_r[1];

    // secure group boundary, writable from secure side only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_cnt_r <= '0;
        end else if (ce && dp_wr_r && bus_r == sctx_pkg::BS_IDLE && dp_sec_r &&
                     dp_addr_r == sctx_pkg::OFF_SEC_GRP) begin
            sec_cnt_r <= (hwdata[GW-1:0] > GW'(N_GROUPS)) ? GW'(N_GROUPS) :
                         hwdata[GW-1:0];
        end
    end

    // group register writes; reset value left undefined
    always_ff @(posedge hclk) begin
        if (ce && dp_wr_r && bus_r == sctx_pkg::BS_IDLE && w_ok) begin
            if (dp_sec_r && {1'b0, widx} < (IW+1)'(sec_cnt_r)) begin
                s2cr_r[widx] <= hwdata & sctx_pkg::S2CR_WMASK;
            end else begin
                // security field is reserved in non-secure groups
                s2cr_r[widx] <= hwdata & sctx_pkg::S2CR_WMASK &
                                ~sctx_pkg::SEC_FIELD_MASK;
            end
        end
    end

    // read mux; sync words read zero, status has only bit 0
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (in_s2cr) begin
            rd_nxt = w_ok ? s2cr_r[widx] : 32'h0000_0000;
        end else begin
            unique case (dp_addr_r)
                sctx_pkg::OFF_NS_STAT: rd_nxt = {31'h0, flag_r[dp_sec_r]};
                sctx_pkg::OFF_AL_STAT: rd_nxt = {31'h0, flag_r[0] & dp_sec_r};
                sctx_pkg::OFF_SEC_GRP: rd_nxt = dp_sec_r ? 32'(sec_cnt_r) : 32'h0000_0000;
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // read data captured at the edge that ends the stall cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ce && bus_r == sctx_pkg::BS_RD_WAIT) begin
            hrdata_r <= rd_nxt;
        end
    end

    // transaction side: group lookup and attribute override
    logic [9:0] grp; // register slot for the incoming group
    logic grp_ok; // slot implemented
    logic [31:0] cfg; // selected group word
    logic grp_sec; // group belongs to secure side
    logic [1:0] ov_tr, ov_fk, ov_pr, ov_wa, ov_ra, ov_sc; // override fields

    // extended matching maps registers onto the last groups
    assign grp = ext_match_enable ? (txn_group - EXT_BASE) : txn_group;
    assign grp_ok = (!ext_match_enable || txn_group >= EXT_BASE) &&
                    (grp < 10'(N_IMPL));
    assign cfg = grp_ok ? s2cr_r[grp[IW-1:0]] : 32'h0000_0000;
    assign grp_sec = {1'b0, grp} < 11'(sec_cnt_r);
    assign ov_tr = cfg[sctx_pkg::F_TRANS+:2];
    assign ov_fk = cfg[sctx_pkg::F_FETCH+:2];
    assign ov_pr = cfg[sctx_pkg::F_PRIV+:2];
    assign ov_wa = cfg[sctx_pkg::F_WALLOC+:2];
    assign ov_ra = cfg[sctx_pkg::F_RALLOC+:2];
    assign ov_sc = cfg[sctx_pkg::F_SEC+:2];

    // registered outputs; reserved codes keep the default
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_valid <= 1'b0;
            out_ctx_type <= 2'h0;
            out_cb_index <= 8'h00;
            out_fault <= 1'b0;
            out_instr <= 1'b0;
            out_priv <= 1'b0;
            out_pan <= 1'b0;
            out_transient <= 1'b0;
            out_walloc <= 1'b0;
            out_ralloc <= 1'b0;
            out_nonsec <= 1'b0;
            out_share <= 2'h0;
            out_mattr <= 4'h0;
        end else if (ce) begin
            out_valid <= txn_valid;
            out_ctx_type <= cfg[sctx_pkg::F_TYPE+:2];
            out_cb_index <= cfg[sctx_pkg::F_CONTEXT_BANK_INDEX+:8];
            // both fault encodings fault the transaction
            out_fault <= txn_valid &&
                (cfg[sctx_pkg::F_TYPE+:2] == sctx_pkg::CTX_FAULT ||
                 cfg[sctx_pkg::F_TYPE+:2] == sctx_pkg::CTX_FAULT_RSVD);
            // transient hint
            unique case (ov_tr)
                sctx_pkg::OV_LOW: out_transient <= 1'b0;
                sctx_pkg::OV_HIGH: out_transient <= 1'b1;
                default: out_transient <= txn_transient;
            endcase
            // fetch kind never applies to writes
            if (txn_write) begin
                out_instr <= 1'b0;
            end else begin
                unique case (ov_fk)
                    sctx_pkg::OV_LOW: out_instr <= 1'b0;
                    sctx_pkg::OV_HIGH: out_instr <= 1'b1;
                    default: out_instr <= txn_instr;
                endcase
            end
            // privilege; hypervisor and monitor banks always privileged
            out_pan <= (ov_pr == sctx_pkg::OV_RSVD) & access_never_support_flag;
            if (txn_hyp_mon_bank) begin
                out_priv <= 1'b1;
            end else begin
                unique case (ov_pr)
                    sctx_pkg::OV_LOW: out_priv <= 1'b0;
                    sctx_pkg::OV_HIGH: out_priv <= 1'b1;
                    default: out_priv <= txn_priv;
                endcase
            end
            // write allocate: 10 allocate, 11 no allocate
            unique case (ov_wa)
                sctx_pkg::OV_LOW: out_walloc <= 1'b1;
                sctx_pkg::OV_HIGH: out_walloc <= 1'b0;
                default: out_walloc <= txn_walloc;
            endcase
            // read allocate only matters for reads
            unique case (ov_ra)
                sctx_pkg::OV_LOW: out_ralloc <= txn_write ? txn_ralloc : 1'b1;
                sctx_pkg::OV_HIGH: out_ralloc <= txn_write ? txn_ralloc : 1'b0;
                default: out_ralloc <= txn_ralloc;
            endcase
            // security override honoured only in secure groups
            if (grp_sec && ov_sc == sctx_pkg::OV_LOW) begin
                out_nonsec <= 1'b0;
            end else if (grp_sec && ov_sc == sctx_pkg::OV_HIGH) begin
                out_nonsec <= 1'b1;
            end else begin
                out_nonsec <= txn_nonsec;
            end
            // shareability code replaces incoming when non-default
            out_share <= (cfg[sctx_pkg::F_SHARE+:2] == sctx_pkg::OV_DEFAULT) ? txn_share :
                         cfg[sctx_pkg::F_SHARE+:2];
            out_mattr <= cfg[sctx_pkg::F_MTSEL] ? cfg[sctx_pkg::F_MATTR+:4] :
                         txn_mattr;
        end
    end

    // hsize unchecked: word transfers only
    logic unused_ok;
    assign unused_ok = ^{hsize, hwdata[31:GW]};
endmodule : sctx_regs
`default_nettype wire

/* File: tb/sctx_regs_monitor.sv */
// checker of sctx_regs ports
// assumes it is bound into sctx_regs
`default_nettype none
module sctx_regs_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hnonsec,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic txn_valid,
    input wire logic txn_write,
    input wire logic txn_hyp_mon_bank,
    input wire logic out_valid,
    input wire logic [1:0] out_ctx_type,
    input wire logic out_fault,
    input wire logic out_instr,
    input wire logic out_priv,
    input wire logic sync_active_ns,
    input wire logic sync_active_s
);
    default clocking mon_ck @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic take; // access taken at this edge
    logic ns_fire, s_fire; // sync data phase ends, per bank
    logic ns_sync_r, s_sync_r; // pending sync data phase, per bank
    assign take = hsel && htrans[1] && hready && ce;
    assign ns_fire = ns_sync_r && hready && ce;
    assign s_fire = s_sync_r && hready && ce;
    // which sync bank the data phase writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ns_sync_r, s_sync_r} <= 2'h0;
        end else if (take) begin
            // the secure alias reaches the non-secure bank
            ns_sync_r <= hwrite && (hnonsec ? haddr == sctx_pkg::OFF_NS_SYNC
                                            : haddr == sctx_pkg::OFF_AL_SYNC);
            s_sync_r <= hwrite && !hnonsec && haddr == sctx_pkg::OFF_NS_SYNC;
        end else if (hready && ce) begin
            {ns_sync_r, s_sync_r} <= 2'h0;
        end
    end
    AST_HRESP_OKAY: assert property (hresp == 1'h0)
        else $error("slave response not okay");
    AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_RD_ONE_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_STAT_RSVD: assert property (take && !hwrite && (haddr == sctx_pkg::OFF_NS_STAT
        || haddr == sctx_pkg::OFF_AL_STAT) |-> ##2 hrdata[31:1] == 31'h0)
        else $error("status reserved bits not zero");
    AST_NS_SET: assert property (ns_fire |=> sync_active_ns)
        else $error("ns sync flag not set");
    AST_S_SET: assert property (s_fire |=> sync_active_s)
        else $error("secure sync flag not set");
    AST_NS_CAUSE: assert property ($rose(sync_active_ns) |-> $past(ns_fire))
        else $error("ns sync flag rose without a write");
    AST_TXN_OUT: assert property (txn_valid && ce |=> out_valid)
        else $error("transaction result missing");
    AST_FAULT: assert property (out_valid |-> out_fault == out_ctx_type[1])
        else $error("fault does not follow context type");
    AST_WR_DATA: assert property (txn_valid && ce && txn_write |=> !out_instr)
        else $error("write marked as instruction");
    AST_HYP_PRIV: assert property (txn_valid && ce && txn_hyp_mon_bank |=> out_priv)
        else $error("hypervisor bank not privileged");
endmodule : sctx_regs_monitor
bind sctx_regs sctx_regs_monitor u_mon (.*);
`default_nettype wire

/* File: tb/stream_context_tlb_sync_regs_test.sv */
// self-checking bench for sctx_regs
// assumes hready looped back from hreadyout
`default_nettype none
module stream_context_tlb_sync_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    // slots 8..15 unimplemented, read zero
    localparam int NIMP = 8;
    logic hclk = 1'h0;
    logic hresetn, hsel, hwrite, hnonsec, hreadyout, hresp, an_flag, ext;
    logic inv_accept, inv_accept_nonsec, inv_done, inv_done_nonsec;
    logic txn_valid, txn_write, txn_instr, txn_priv, txn_transient, txn_walloc;
    logic txn_ralloc, txn_nonsec, txn_hyp_mon_bank, out_valid, out_fault, out_instr;
    logic out_priv, out_pan, out_transient, out_walloc, out_ralloc, out_nonsec;
    logic sync_active_ns, sync_active_s;
    logic [1:0] htrans, txn_share, out_ctx_type, out_share;
    logic [3:0] txn_mattr, out_mattr;
    logic [7:0] out_cb_index;
    logic [9:0] txn_group;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata, rd, d, s;
    logic [31:0] seed = 32'h0000_0074; // xorshift state
    logic [31:0] mem [16]; // expected group contents
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    sctx_regs #(.N_IMPL(NIMP)) DUT (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hnonsec(hnonsec),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .inv_accept(inv_accept), .inv_accept_nonsec(inv_accept_nonsec),
        .inv_done(inv_done), .inv_done_nonsec(inv_done_nonsec),
        .access_never_support_flag(an_flag), .ext_match_enable(ext),
        .txn_valid(txn_valid), .txn_group(txn_group), .txn_write(txn_write),
        .txn_instr(txn_instr), .txn_priv(txn_priv), .txn_transient(txn_transient),
        .txn_walloc(txn_walloc), .txn_ralloc(txn_ralloc), .txn_nonsec(txn_nonsec),
        .txn_share(txn_share), .txn_mattr(txn_mattr), .txn_hyp_mon_bank(txn_hyp_mon_bank),
        .out_valid(out_valid), .out_ctx_type(out_ctx_type), .out_cb_index(out_cb_index),
        .out_fault(out_fault), .out_instr(out_instr), .out_priv(out_priv),
        .out_pan(out_pan), .out_transient(out_transient), .out_walloc(out_walloc),
        .out_ralloc(out_ralloc), .out_nonsec(out_nonsec), .out_share(out_share),
        .out_mattr(out_mattr), .sync_active_ns(sync_active_ns),
        .sync_active_s(sync_active_s)
    );
    // 250 mhz clock
    initial begin
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // override: 10 low, 11 high, else incoming
    function automatic logic ov(input logic [1:0] c, input logic in);
        return c[1] ? c[0] : in;
    endfunction : ov
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // one word transfer; read data taken at the last edge
    task automatic ahb(input logic wr, input logic ns, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hnonsec <= ns;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    // one-cycle invalidation events
    task automatic pulse(input logic acc, input logic dn, input logic ns);
        @(posedge hclk);
        inv_accept <= acc;
        inv_done <= dn;
        {inv_accept_nonsec, inv_done_nonsec} <= {ns, ns};
        @(posedge hclk);
        inv_accept <= 1'h0;
        inv_done <= 1'h0;
    endtask : pulse
    // compare with the model; groups 0..3 secure
    task automatic chk_txn(input logic [31:0] v);
        logic [31:0] c;
        c = mem[v[3:0]];
        chk(out_valid, 1);
        chk(out_ctx_type, c[17:16]);
        chk(out_fault, c[17]);
        if (c[17:16] == 2'h0) chk(out_cb_index, c[7:0]);
        chk(out_mattr, c[11] ? c[15:12] : v[16:13]);
        chk(out_share, v[12:11]);
        chk(out_transient, ov(c[29:28], v[7]));
        chk(out_instr, v[4] ? 1'h0 : ov(c[27:26], v[5]));
        chk(out_priv, v[17] | ov(c[25:24], v[6]));
        chk(out_pan, c[25:24] == 2'h1 && v[18]);
        chk(out_walloc, !ov(c[23:22], !v[8]));
        chk(out_ralloc, v[4] ? v[9] : !ov(c[21:20], !v[9]));
        chk(out_nonsec, v[3:0] < 4 ? ov(c[19:18], v[10]) : v[10]);
    endtask : chk_txn
    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {hsel, hwrite, hnonsec, htrans, haddr, hwdata, an_flag, txn_valid, ext} = '0;
        {inv_accept, inv_accept_nonsec, inv_done, inv_done_nonsec} = '0;
        {txn_group, txn_write, txn_instr, txn_priv, txn_transient, txn_walloc} = '0;
        {txn_ralloc, txn_nonsec, txn_share, txn_mattr, txn_hyp_mon_bank} = '0;
        hresetn = 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        // status reset value, write ignored, unmapped reads zero
        ahb(0, 1, sctx_pkg::OFF_NS_STAT, 0);
        chk(rd, 0);
        ahb(1, 1, sctx_pkg::OFF_NS_STAT, 32'hFFFF_FFFF);
        ahb(0, 1, sctx_pkg::OFF_NS_STAT, 0);
        chk(rd, 0);
        ahb(0, 0, 12'h3F0, 0);
        chk(rd, 0);
        $display("status test done");
        // nothing pending: flag up one cycle
        ahb(1, 0, sctx_pkg::OFF_NS_SYNC, seed);
        #1 chk(sync_active_s, 1);
        chk(sync_active_ns, 0);
        @(posedge hclk);
        #1 chk(sync_active_s, 0);
        // pending secure invalidation leaves ns sync
        pulse(1, 0, 0);
        ahb(1, 1, sctx_pkg::OFF_NS_SYNC, 0);
        @(posedge hclk);
        #1 chk(sync_active_ns, 0);
        pulse(0, 1, 0);
        // pending ns invalidation holds ns sync
        pulse(1, 0, 1);
        ahb(1, 1, sctx_pkg::OFF_NS_SYNC, 0);
        ahb(0, 1, sctx_pkg::OFF_NS_STAT, 0);
        chk(rd, 1);
        ahb(0, 0, sctx_pkg::OFF_NS_STAT, 0);
        chk(rd, 0);
        ahb(0, 0, sctx_pkg::OFF_AL_STAT, 0);
        chk(rd, 1);
        pulse(0, 1, 1);
        repeat (2) @(posedge hclk);
        #1 chk(sync_active_ns, 0);
        // the secure alias starts the ns sync
        pulse(1, 0, 1);
        ahb(1, 0, sctx_pkg::OFF_AL_SYNC, 0);
        #1 chk(sync_active_ns, 1);
        pulse(0, 1, 1);
        $display("sync test done");
        ahb(1, 0, sctx_pkg::OFF_SEC_GRP, 4);
        for (int r = 0; r < 4; r++) begin
            ext <= r == 3;
            // fill groups from their own side; shareability default
            for (int g = 0; g < 16; g++) begin
                seed = xs(seed);
                d = seed & 32'hFFFF_FCFF;
                if (d[11] && (d[15:14] == 2'h0 || d[15:12] == 4'h5)) begin
                    d = d & 32'hCF0F_FCFF | 32'h20F0_0000;
                end
                mem[g] = g >= NIMP ? 32'h0 : d & sctx_pkg::S2CR_WMASK
                         & (g < 4 ? 32'hFFFF_FFFF : ~sctx_pkg::SEC_FIELD_MASK);
                ahb(1, g >= 4, sctx_pkg::OFF_S2CR + 12'(4 * g), d);
            end
            // ns side may not reach a secure group
            ahb(1, 1, sctx_pkg::OFF_S2CR, 32'h0);
            for (int g = 0; g < 16; g++) begin
                ahb(0, g >= 4, sctx_pkg::OFF_S2CR + 12'(4 * g), 0);
                chk(rd, mem[g]);
            end
            for (int n = 0; n < 50; n++) begin
                seed = xs(seed);
                s = seed;
                @(posedge hclk);
                txn_valid <= 1'h1;
                // last 128 of 1024 groups when extended matching is on
                txn_group <= {ext ? 3'h7 : 3'h0, 3'h0, s[3:0]};
                {txn_transient, txn_priv, txn_instr, txn_write} <= s[7:4];
                {txn_nonsec, txn_ralloc, txn_walloc} <= s[10:8];
                {txn_hyp_mon_bank, txn_mattr, txn_share} <= s[17:11];
                an_flag <= s[18];
                @(posedge hclk);
                #1 chk_txn(s);
            end
            @(posedge hclk);
            txn_valid <= 1'h0;
        end
        $display("group test done");
        test_done();
    end
endmodule : stream_context_tlb_sync_regs_test
`default_nettype wire
